//--- shared/sample_fifo_pkg.sv
/*
 * Constants shared by the accelerometer sample buffer: register indices, field
 * positions, reset values, capacities, modes and channel tags.
 * Assumes a register index is a word index; the byte address is four times it.
 */
// Functional notes
// R1: Storage holds 320 sixteen-bit sample words.
// R2: With exactly three channels enabled only 318 locations are used.
// R3: Words are stored X, Y, Z, T in order, skipping disabled channels.
// R4: The data register never auto-increments, so bursts keep draining words.
// R5: A burst below the data register increments up to it, then holds there.
// R6: The host reads every word of a set within one burst.
// R7: Tag enable, config low bit 6, puts a 2-bit tag before each word.
// R8: Tags are 00 for X, 01 for Y, 10 for Z, 11 for temperature.
// R9: Tags are made at read time and take no storage location; the code makes them at write time and stores them in two extra bits per word.
// R10: Mode 00 stores nothing and data reads return zero.
// R11: Mode 01 fills, stops when full, sets full bit 1, resumes after reads.
// R12: Mode 10 drops the oldest whole set to make room for the newest.
// R13: Watermark threshold is config low bit 0 over config high bits 7:0.
// R14: Mode 11 streams until an activity or external trigger arrives.
// R15: After a trigger, exactly threshold further words are stored, then frozen.
// R16: With external trigger enable, bit 3, a frame-sync edge triggers capture.
// R17: Mode, threshold and tag enable are writable in config low and high.
// R18: Watermark status bit 3 is high while count is at or above threshold.
// R19: Ready status bit 4 is high while at least one word is stored.
// R20: In modes 01 and 11 overrun bit 2 sets on lost data; reads clear it.
// R21: Full sets at 320 words, or 318 with exactly three channels.
// R22: Words read as two bytes, high byte first, removed after the low byte.
// R23: Writing a new mode flushes contents, pointers and trigger state.
package sample_fifo_pkg;

	localparam int          DEPTH       = 320;
	localparam int          DEPTH_3CH   = 318;
	localparam int          PTR_W       = 9;
	localparam int          WORD_W      = 16;
	localparam int          TAG_W       = 2;
	localparam int          IDX_W       = 7;

	localparam logic [6:0]  IDX_STATUS  = 7'h11;
	localparam logic [6:0]  IDX_DATA    = 7'h1D;
	localparam logic [6:0]  IDX_CFG_LO  = 7'h30;
	localparam logic [6:0]  IDX_CFG_HI  = 7'h31;
	localparam logic [6:0]  IDX_CH_EN   = 7'h32;
	localparam logic [6:0]  IDX_COUNT   = 7'h33;
	localparam logic [6:0]  IDX_CURSOR  = 7'h3E;
	localparam logic [6:0]  IDX_WINDOW  = 7'h3F;

	localparam int          BIT_TAG_EN  = 6;
	localparam int          BIT_MODE_HI = 5;
	localparam int          BIT_MODE_LO = 4;
	localparam int          BIT_EXT_TRG = 3;
	localparam int          BIT_THR_MSB = 0;

	localparam int          BIT_READY   = 4;
	localparam int          BIT_WMARK   = 3;
	localparam int          BIT_OVERRUN = 2;
	localparam int          BIT_FULL    = 1;

	localparam logic [7:0]  CFG_LO_RST  = 8'h00;
	localparam logic [7:0]  CFG_HI_RST  = 8'h00;
	localparam logic [3:0]  CH_EN_RST   = 4'hF;
	localparam logic [6:0]  CURSOR_RST  = 7'h00;

	typedef enum logic [1:0] {
		MODE_OFF     = 2'b00,
		MODE_FIRST_N = 2'b01,
		MODE_LAST_N  = 2'b10,
		MODE_TRIGGER = 2'b11
	} buf_mode_t;

	typedef enum logic [1:0] {
		TRG_WAIT   = 2'b00,
		TRG_POST   = 2'b01,
		TRG_FROZEN = 2'b11
	} trg_state_t;

	typedef enum logic [1:0] {
		PH_TAG = 2'b00,
		PH_MSB = 2'b01,
		PH_LSB = 2'b11
	} byte_phase_t;

	localparam logic [1:0]  TAG_X       = 2'b00;
	localparam logic [1:0]  TAG_Y       = 2'b01;
	localparam logic [1:0]  TAG_Z       = 2'b10;
	localparam logic [1:0]  TAG_T       = 2'b11;

endpackage : sample_fifo_pkg

//--- hdl/pin_sync.sv
/*
 * Two-stage synchroniser for a single asynchronous level.
 * Assumes the input is a pin with no relation to CLK.
 */
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic pin_in,
	output logic      level_out
);
	logic meta_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_reg  <= 1'b0;
			level_out <= 1'b0;
		end else begin
			meta_reg  <= pin_in;
			level_out <= meta_reg;
		end
	end
endmodule : pin_sync
`default_nettype wire

//--- hdl/sample_store.sv
/*
 * Sample storage array: one write port, one asynchronous read port.
 * Assumes the caller keeps both addresses inside the array.
 */
`timescale 1ns/1ns
`default_nettype none
module sample_store (
	input  wire logic                                 clk,
	input  wire logic                                 wr_en,
	input  wire logic [sample_fifo_pkg::PTR_W-1:0]    wr_addr,
	input  wire logic [sample_fifo_pkg::TAG_W+sample_fifo_pkg::WORD_W-1:0] wr_data,
	input  wire logic [sample_fifo_pkg::PTR_W-1:0]    rd_addr,
	output logic      [sample_fifo_pkg::TAG_W+sample_fifo_pkg::WORD_W-1:0] rd_data
);
	// R1 word array
	logic [sample_fifo_pkg::TAG_W+sample_fifo_pkg::WORD_W-1:0] mem [sample_fifo_pkg::DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];
endmodule : sample_store
`default_nettype wire

//--- hdl/accel_sample_fifo.sv
/*
 * Accelerometer sample buffer with Avalon-MM register slave.
 * Assumes sample sets arrive from the sampling logic on CLK, at most one set
 * every five cycles, and that ACTIVITY_EVENT is a one-cycle pulse on CLK.
 */
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module accel_sample_fifo (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic [8:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic        SAMPLE_VALID,
	input  wire logic [15:0] SAMPLE_X,
	input  wire logic [15:0] SAMPLE_Y,
	input  wire logic [15:0] SAMPLE_Z,
	input  wire logic [15:0] SAMPLE_T,
	input  wire logic        ACTIVITY_EVENT,
	input  wire logic        FRAME_SYNC_PIN
);
	localparam logic [8:0] CAP_FULL = 9'(sample_fifo_pkg::DEPTH);
	localparam logic [8:0] CAP_3CH  = 9'(sample_fifo_pkg::DEPTH_3CH);

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	logic [7:0]                       cfg_lo_reg;
	logic [7:0]                       cfg_hi_reg;
	logic [3:0]                       ch_en_reg;
	logic [6:0]                       cursor_reg;
	logic                             overrun_reg;
	logic [8:0]                       count_reg;
	logic [8:0]                       wptr_reg;
	logic [8:0]                       rptr_reg;
	logic [3:0]                       pending_reg;
	logic [63:0]                      set_reg;
	sample_fifo_pkg::trg_state_t      trg_reg;
	sample_fifo_pkg::byte_phase_t     phase_reg;
	logic [8:0]                       post_reg;
	logic                             frame_sync_pin_prev_reg;

	logic                             frame_sync_pin_lvl;
	logic [17:0]                      rd_word;
	logic [17:0]                      wr_word;
	sample_fifo_pkg::buf_mode_t       mode;
	logic [8:0]                       cap;
	logic [8:0]                       thr;
	logic [2:0]                       n_en;
	logic                             fire;
	logic [6:0]                       eff_idx;
	logic                             flush;
	logic                             pop;
	logic                             push;
	logic                             start;
	logic                             need_drop;
	logic                             keep_set;
	logic                             drop;
	logic                             trigger;
	logic [7:0]                       rd_value;
	logic [1:0]                       push_tag;
	logic [15:0]                      push_data;
	logic [9:0]                       rnext;

	assign mode = sample_fifo_pkg::buf_mode_t'(cfg_lo_reg[sample_fifo_pkg::BIT_MODE_HI:
		sample_fifo_pkg::BIT_MODE_LO]);
	// R13 nine-bit threshold
	assign thr  = {cfg_lo_reg[sample_fifo_pkg::BIT_THR_MSB], cfg_hi_reg};
	assign n_en = 3'(ch_en_reg[0]) + 3'(ch_en_reg[1]) + 3'(ch_en_reg[2]) + 3'(ch_en_reg[3]);
	// R2 three-channel depth
	assign cap  = (n_en == 3'h3) ? CAP_3CH : CAP_FULL;

	// ------------------------------------------------------------------
	// Bus handshake: one wait state, action at the accepting edge
	// ------------------------------------------------------------------
	assign fire    = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
	// R5 burst window indirection
	assign eff_idx = (AVS_ADDRESS[8:2] == sample_fifo_pkg::IDX_WINDOW) ? cursor_reg
		: AVS_ADDRESS[8:2];
	// R23 flush on mode change
	assign flush   = fire & AVS_WRITE & AVS_BYTEENABLE[0]
		& (eff_idx == sample_fifo_pkg::IDX_CFG_LO)
		& (AVS_WRITEDATA[sample_fifo_pkg::BIT_MODE_HI:sample_fifo_pkg::BIT_MODE_LO]
			!= cfg_lo_reg[sample_fifo_pkg::BIT_MODE_HI:sample_fifo_pkg::BIT_MODE_LO]);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
		end
	end

	// ------------------------------------------------------------------
	// Read data path
	// ------------------------------------------------------------------
	always_comb begin
		rd_value = 8'h00;
		case (eff_idx)
			sample_fifo_pkg::IDX_STATUS: begin
				// R19 ready flag
				rd_value[sample_fifo_pkg::BIT_READY]   = (count_reg != 9'h000);
				// R18 watermark level
				rd_value[sample_fifo_pkg::BIT_WMARK]   = (count_reg >= thr);
				rd_value[sample_fifo_pkg::BIT_OVERRUN] = overrun_reg;
				// R21 full level
				rd_value[sample_fifo_pkg::BIT_FULL]    = (count_reg >= cap);
			end
			sample_fifo_pkg::IDX_DATA: begin
				// R10 disabled reads zero
				if (mode == sample_fifo_pkg::MODE_OFF || count_reg == 9'h000) begin
					rd_value = 8'h00;
				end else begin
					case (phase_reg)
						// R9 tag from word side bits
						sample_fifo_pkg::PH_TAG: rd_value = {6'h00, rd_word[17:16]};
						// R22 high byte first
						sample_fifo_pkg::PH_MSB: rd_value = rd_word[15:8];
						default:                 rd_value = rd_word[7:0];
					endcase
				end
			end
			sample_fifo_pkg::IDX_CFG_LO: rd_value = cfg_lo_reg;
			sample_fifo_pkg::IDX_CFG_HI: rd_value = cfg_hi_reg;
			sample_fifo_pkg::IDX_CH_EN:  rd_value = {4'h0, ch_en_reg};
			sample_fifo_pkg::IDX_COUNT:  rd_value = count_reg[7:0];
			sample_fifo_pkg::IDX_CURSOR: rd_value = {1'b0, cursor_reg};
			default:                     rd_value = 8'h00;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (AVS_READ & AVS_WAITREQUEST) begin
			AVS_READDATA <= {24'h00_0000, rd_value};
		end
	end

	// ------------------------------------------------------------------
	// Software-written registers
	// ------------------------------------------------------------------
	// R17 configuration writes
	always_ff @(posedge CLK) begin
		if (RESET) begin
			cfg_lo_reg <= sample_fifo_pkg::CFG_LO_RST;
			cfg_hi_reg <= sample_fifo_pkg::CFG_HI_RST;
			ch_en_reg  <= sample_fifo_pkg::CH_EN_RST;
		end else if (fire & AVS_WRITE & AVS_BYTEENABLE[0]) begin
			case (eff_idx)
				sample_fifo_pkg::IDX_CFG_LO: cfg_lo_reg <= AVS_WRITEDATA[7:0];
				sample_fifo_pkg::IDX_CFG_HI: cfg_hi_reg <= AVS_WRITEDATA[7:0];
				sample_fifo_pkg::IDX_CH_EN:  ch_en_reg  <= AVS_WRITEDATA[3:0];
				default: begin
				end
			endcase
		end
	end

	// Burst cursor: set by software, steps once per window access except at the data register.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			cursor_reg <= sample_fifo_pkg::CURSOR_RST;
		end else if (fire & AVS_WRITE & AVS_BYTEENABLE[0]
			& (AVS_ADDRESS[8:2] == sample_fifo_pkg::IDX_CURSOR)) begin
			cursor_reg <= AVS_WRITEDATA[6:0];
		// R4 cursor holds at data register
		end else if (fire & (AVS_ADDRESS[8:2] == sample_fifo_pkg::IDX_WINDOW)
			& (cursor_reg != sample_fifo_pkg::IDX_DATA)) begin
			// R5 increment below data register
			cursor_reg <= cursor_reg + 7'h01;
		end
	end

	// ------------------------------------------------------------------
	// Read side: byte phase and word removal
	// ------------------------------------------------------------------
	assign pop = fire & AVS_READ & (eff_idx == sample_fifo_pkg::IDX_DATA)
		& (mode != sample_fifo_pkg::MODE_OFF) & (count_reg != 9'h000)
		& (phase_reg == sample_fifo_pkg::PH_LSB);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			phase_reg <= sample_fifo_pkg::PH_MSB;
		end else if (flush | drop | (mode == sample_fifo_pkg::MODE_OFF)) begin
			// A mode write brings its own tag enable, which is not in cfg_lo_reg yet.
			phase_reg <= (flush ? AVS_WRITEDATA[sample_fifo_pkg::BIT_TAG_EN]
				: cfg_lo_reg[sample_fifo_pkg::BIT_TAG_EN]) ? sample_fifo_pkg::PH_TAG
				: sample_fifo_pkg::PH_MSB;
		end else if (fire & AVS_READ & (eff_idx == sample_fifo_pkg::IDX_DATA)
			& (count_reg != 9'h000)) begin
			case (phase_reg)
				sample_fifo_pkg::PH_TAG: phase_reg <= sample_fifo_pkg::PH_MSB;
				sample_fifo_pkg::PH_MSB: phase_reg <= sample_fifo_pkg::PH_LSB;
				// R7 tag before next word
				default: phase_reg <= cfg_lo_reg[sample_fifo_pkg::BIT_TAG_EN]
					? sample_fifo_pkg::PH_TAG : sample_fifo_pkg::PH_MSB;
			endcase
		end else if ((phase_reg == sample_fifo_pkg::PH_TAG)
			& ~cfg_lo_reg[sample_fifo_pkg::BIT_TAG_EN]) begin
			// A tag byte still due when tagging is switched off is skipped.
			phase_reg <= sample_fifo_pkg::PH_MSB;
		end
	end

	// ------------------------------------------------------------------
	// Trigger detection
	// ------------------------------------------------------------------
	pin_sync frame_sync_pin_sync (
		.clk       (CLK),
		.reset     (RESET),
		.pin_in    (FRAME_SYNC_PIN),
		.level_out (frame_sync_pin_lvl)
	);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			frame_sync_pin_prev_reg <= 1'b0;
		end else begin
			frame_sync_pin_prev_reg <= frame_sync_pin_lvl;
		end
	end

	// R16 frame-sync edge trigger
	assign trigger = ACTIVITY_EVENT | (cfg_lo_reg[sample_fifo_pkg::BIT_EXT_TRG]
		& frame_sync_pin_lvl & ~frame_sync_pin_prev_reg);

	// R14 stream until trigger
	always_ff @(posedge CLK) begin
		if (RESET) begin
			trg_reg  <= sample_fifo_pkg::TRG_WAIT;
			post_reg <= 9'h000;
		end else if (flush | (mode != sample_fifo_pkg::MODE_TRIGGER)) begin
			trg_reg  <= sample_fifo_pkg::TRG_WAIT;
			post_reg <= 9'h000;
		end else begin
			case (trg_reg)
				sample_fifo_pkg::TRG_WAIT: begin
					if (trigger) begin
						trg_reg  <= (thr == 9'h000) ? sample_fifo_pkg::TRG_FROZEN
							: sample_fifo_pkg::TRG_POST;
						post_reg <= 9'h000;
					end
				end
				sample_fifo_pkg::TRG_POST: begin
					// R15 freeze after threshold words
					if (push) begin
						post_reg <= post_reg + 9'h001;
						if (post_reg + 9'h001 >= thr) begin
							trg_reg <= sample_fifo_pkg::TRG_FROZEN;
						end
					end
				end
				sample_fifo_pkg::TRG_FROZEN: trg_reg <= sample_fifo_pkg::TRG_FROZEN;
				default: trg_reg <= sample_fifo_pkg::TRG_WAIT;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Write side: set acceptance, oldest-set drop, word serialising
	// ------------------------------------------------------------------
	assign start     = SAMPLE_VALID & (pending_reg == 4'h0) & (ch_en_reg != 4'h0)
		& (mode != sample_fifo_pkg::MODE_OFF) & (trg_reg != sample_fifo_pkg::TRG_FROZEN)
		& ~flush;
	assign need_drop = (cap - count_reg) < 9'(n_en);
	// R11 first-N refuses when full
	assign keep_set  = start & ~(need_drop & (mode == sample_fifo_pkg::MODE_FIRST_N));
	// R12 drop oldest set
	assign drop      = start & need_drop & (mode != sample_fifo_pkg::MODE_FIRST_N);
	assign push      = (pending_reg != 4'h0) & (trg_reg != sample_fifo_pkg::TRG_FROZEN)
		& (mode != sample_fifo_pkg::MODE_OFF);

	// R3 fixed channel order
	always_comb begin
		push_tag  = sample_fifo_pkg::TAG_T;
		push_data = set_reg[63:48];
		// R8 channel tag codes
		if (pending_reg[0]) begin
			push_tag  = sample_fifo_pkg::TAG_X;
			push_data = set_reg[15:0];
		end else if (pending_reg[1]) begin
			push_tag  = sample_fifo_pkg::TAG_Y;
			push_data = set_reg[31:16];
		end else if (pending_reg[2]) begin
			push_tag  = sample_fifo_pkg::TAG_Z;
			push_data = set_reg[47:32];
		end
	end

	assign wr_word = {push_tag, push_data};

	always_ff @(posedge CLK) begin
		if (RESET) begin
			pending_reg <= 4'h0;
			set_reg     <= 64'h0;
		end else if (flush | (mode == sample_fifo_pkg::MODE_OFF)
			| (trg_reg == sample_fifo_pkg::TRG_FROZEN)) begin
			pending_reg <= 4'h0;
		end else if (keep_set) begin
			pending_reg <= ch_en_reg;
			set_reg     <= {SAMPLE_T, SAMPLE_Z, SAMPLE_Y, SAMPLE_X};
		end else if (push) begin
			pending_reg <= pending_reg & (pending_reg - 4'h1);
		end
	end

	sample_store store (
		.clk     (CLK),
		.wr_en   (push),
		.wr_addr (wptr_reg),
		.wr_data (wr_word),
		.rd_addr (rptr_reg),
		.rd_data (rd_word)
	);

	// ------------------------------------------------------------------
	// Pointers, count and overrun
	// ------------------------------------------------------------------
	assign rnext = 10'(rptr_reg) + 10'(pop) + (drop ? 10'(n_en) : 10'h000);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			wptr_reg  <= 9'h000;
			rptr_reg  <= 9'h000;
			count_reg <= 9'h000;
		end else if (flush | (mode == sample_fifo_pkg::MODE_OFF)) begin
			// R10 nothing stored
			wptr_reg  <= 9'h000;
			rptr_reg  <= 9'h000;
			count_reg <= 9'h000;
		end else begin
			if (push) begin
				wptr_reg <= (wptr_reg + 9'h001 >= cap) ? 9'h000 : wptr_reg + 9'h001;
			end
			rptr_reg  <= (rnext >= 10'(cap)) ? 9'(rnext - 10'(cap)) : rnext[8:0];
			count_reg <= count_reg + 9'(push) - 9'(pop) - (drop ? 9'(n_en) : 9'h000);
		end
	end

	// R20 overrun set wins over clear
	always_ff @(posedge CLK) begin
		if (RESET) begin
			overrun_reg <= 1'b0;
		end else if (flush | (mode == sample_fifo_pkg::MODE_OFF)) begin
			overrun_reg <= 1'b0;
		end else if ((start & need_drop & (mode == sample_fifo_pkg::MODE_FIRST_N))
			| (drop & (mode == sample_fifo_pkg::MODE_TRIGGER))) begin
			overrun_reg <= 1'b1;
		end else if (pop) begin
			overrun_reg <= 1'b0;
		end
	end
endmodule : accel_sample_fifo
`default_nettype wire

//--- dv/host_model.sv
/* Host processor model: a register bus master on the buffer's slave port.
   Assumes one clock, and that the bench calls acc() one access at a time. */
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input  wire logic        clk,
	input  wire logic        waitreq,
	output logic      [8:0]  address,
	output logic             read,
	output logic             write,
	output logic      [31:0] writedata,
	output logic      [3:0]  byteenable
);
	initial begin
		address = 9'h000;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		byteenable = 4'h0;
	end

	// one register access per call
	// The request is held until waitrequest is seen low, then released.
	task automatic acc(input logic wr, input logic [6:0] idx, input logic [7:0] d);
		@(posedge clk);
		address <= {idx, 2'b00};
		writedata <= {24'h000000, d};
		byteenable <= 4'hF;
		read <= !wr;
		write <= wr;
		do @(posedge clk); while (waitreq !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask : acc
endmodule : host_model
`default_nettype wire

//--- dv/accel_sample_fifo_sva.sv
/* Checker for the buffer register port: readback, mode-off behaviour and
   status flag relations. Assumes it is bound to the buffer top module. */
`timescale 1ns/1ns
`default_nettype none
module fifo_port_checker (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic [8:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	input  wire logic [31:0] AVS_READDATA,
	input  wire logic        AVS_WAITREQUEST
);
	localparam logic [6:0] i_st = sample_fifo_pkg::IDX_STATUS;
	localparam logic [6:0] i_lo = sample_fifo_pkg::IDX_CFG_LO;
	localparam logic [6:0] i_hi = sample_fifo_pkg::IDX_CFG_HI;
	logic       rd_acc;
	logic       wr_acc;
	logic [6:0] idx;
	logic [7:0] rb;
	logic [8:0] thr;
	logic [7:0] lo_reg;
	logic [7:0] hi_reg;

	assign idx    = AVS_ADDRESS[8:2];
	assign rb     = AVS_READDATA[7:0];
	assign rd_acc = AVS_READ && !AVS_WAITREQUEST;
	assign wr_acc = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
	assign thr    = {lo_reg[0], hi_reg};

	// Shadow copies of the configuration follow every accepted write to their own index; writes through the window are not seen.
	always_ff @(posedge CLK) begin
		if (RESET) lo_reg <= 8'h00;
		else if (wr_acc && idx == i_lo) lo_reg <= AVS_WRITEDATA[7:0];
	end

	always_ff @(posedge CLK) begin
		if (RESET) hi_reg <= 8'h00;
		else if (wr_acc && idx == i_hi) hi_reg <= AVS_WRITEDATA[7:0];
	end

	// ----
	// Properties
	// ----
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	sequence st_rd;
		rd_acc && idx == i_st;
	endsequence

	a_off_data_zero:
		assert property (rd_acc && idx == sample_fifo_pkg::IDX_DATA && lo_reg[5:4] == 2'h0
		|-> rb == 8'h00) else $error("data read not zero while off");
	a_off_status_empty:
		assert property (st_rd ##0 lo_reg[5:4] == 2'h0 |-> rb[4:1] == {1'b0, thr == 9'h000, 2'h0})
		else $error("status flags wrong while off");
	a_cfg_lo_back:
		assert property (rd_acc && idx == i_lo |-> rb == lo_reg) else $error("config low readback");
	a_cfg_hi_back:
		assert property (rd_acc && idx == i_hi |-> rb == hi_reg) else $error("config high readback");
	a_full_ready:
		assert property (st_rd ##0 rb[1] |-> rb[4]) else $error("full without ready");
	a_wmark_ready:
		assert property (st_rd ##0 (rb[3] && thr != 9'h000) |-> rb[4]) else $error("watermark empty");
	a_zero_thr_mark:
		assert property (st_rd ##0 thr == 9'h000 |-> rb[3]) else $error("zero threshold unmarked");
	a_full_wmark:
		assert property (st_rd ##0 (rb[1] && thr <= 9'h13E) |-> rb[3]) else $error("full below mark");

	c_full: cover property (st_rd ##0 rb[1]);
	c_overrun: cover property (st_rd ##0 rb[2]);
	c_data: cover property (rd_acc && idx == sample_fifo_pkg::IDX_DATA && rb != 8'h00);
endmodule : fifo_port_checker

bind accel_sample_fifo fifo_port_checker port_chk (.CLK(CLK), .RESET(RESET),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
`default_nettype wire

//--- dv/testbench.sv
/* Self-checking bench: the host model reaches the registers, the bench
   feeds sample sets and triggers. Assumes the checker binds itself. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [6:0] i_st  = sample_fifo_pkg::IDX_STATUS;
	localparam logic [6:0] i_dt  = sample_fifo_pkg::IDX_DATA;
	localparam logic [6:0] i_lo  = sample_fifo_pkg::IDX_CFG_LO;
	localparam logic [6:0] i_hi  = sample_fifo_pkg::IDX_CFG_HI;
	localparam logic [6:0] i_en  = sample_fifo_pkg::IDX_CH_EN;
	localparam logic [6:0] i_cnt = sample_fifo_pkg::IDX_COUNT;
	localparam logic [6:0] i_cur = sample_fifo_pkg::IDX_CURSOR;
	localparam logic [6:0] i_win = sample_fifo_pkg::IDX_WINDOW;
	logic        clk;
	logic        reset;
	logic        s_valid;
	logic        act;
	logic        frame_sync_pin;
	logic [15:0] smp[4];
	logic [8:0]  address;
	logic        rd;
	logic        wr;
	logic        waitreq;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0]  be;
	logic [17:0] wq[$];
	logic [7:0]  eq[$];
	integer      seed = 32'hFE13;
	int          fail_count = 0;
	int          total_checks = 0;

	accel_sample_fifo dut (.CLK(clk), .RESET(reset), .AVS_ADDRESS(address), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .SAMPLE_VALID(s_valid), .SAMPLE_X(smp[0]),
		.SAMPLE_Y(smp[1]), .SAMPLE_Z(smp[2]), .SAMPLE_T(smp[3]),
		.ACTIVITY_EVENT(act), .FRAME_SYNC_PIN(frame_sync_pin));
	host_model host (.clk(clk), .waitreq(waitreq), .address(address), .read(rd),
		.write(wr), .writedata(wdata), .byteenable(be));

	// ----
	// Tasks
	// ----
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic rd_exp(input logic [6:0] idx, input logic [7:0] exp);
		eq.push_back(exp);
		host.acc(1'b0, idx, 8'h00);
	endtask : rd_exp

	task automatic wr_reg(input logic [6:0] idx, input logic [7:0] d);
		host.acc(1'b1, idx, d);
	endtask : wr_reg

	task automatic word(input bit tag_on, input logic [6:0] idx);
		logic [17:0] w;
		w = wq.pop_front();
		if (tag_on) rd_exp(idx, {6'h00, w[17:16]});
		rd_exp(idx, w[15:8]);
		rd_exp(idx, w[7:0]);
	endtask : word

	// Sends one random sample set; kept words are noted in X, Y, Z, T order.
	task automatic set_in(input logic [3:0] en, input bit keep);
		logic [15:0] v[4];
		foreach (v[i]) v[i] = 16'($random(seed));
		@(posedge clk);
		foreach (v[i]) smp[i] <= v[i];
		s_valid <= 1'b1;
		@(posedge clk);
		s_valid <= 1'b0;
		repeat (4) @(posedge clk);
		foreach (v[i]) if (keep && en[i]) wq.push_back({2'(i), v[i]});
	endtask : set_in

	task automatic close_out();
		if (fail_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		if (rd && !waitreq) chk("readdata", rdata, {24'h000000, eq.pop_front()});
	end

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		close_out();
	end

	// ----
	// Scenarios
	// ----
	initial begin
		int         n;
		logic [7:0] a;
		logic [7:0] b;
		reset = 1'b1;
		s_valid = 1'b0;
		act = 1'b0;
		frame_sync_pin = 1'b0;
		foreach (smp[i]) smp[i] = 16'h0000;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		rd_exp(i_lo, 8'h00);
		rd_exp(i_st, 8'h08);
		rd_exp(7'h7F, 8'h00);
		for (n = 0; n < 3; n++) begin
			a = 8'($random(seed));
			b = 8'($random(seed)) & 8'h49;
			wr_reg(i_hi, a);
			wr_reg(i_lo, b);
			rd_exp(i_hi, a);
			rd_exp(i_lo, b);
		end
		wr_reg(i_hi, 8'h05);
		wr_reg(i_lo, 8'h00);
		set_in(4'hF, 1'b0);
		rd_exp(i_dt, 8'h00);
		rd_exp(i_st, 8'h00);
		wr_reg(i_en, 8'h0B);
		wr_reg(i_hi, 8'h02);
		wr_reg(i_lo, 8'h50);
		repeat (2) set_in(4'hB, 1'b1);
		rd_exp(i_st, 8'h18);
		repeat (6) word(1'b1, i_dt);
		rd_exp(i_st, 8'h00);
		wr_reg(i_hi, 8'h2C);
		wr_reg(i_lo, 8'h11);
		repeat (106) set_in(4'hB, 1'b1);
		rd_exp(i_st, 8'h1A);
		set_in(4'hB, 1'b0);
		rd_exp(i_st, 8'h1E);
		repeat (3) word(1'b0, i_dt);
		rd_exp(i_st, 8'h18);
		set_in(4'hB, 1'b1);
		rd_exp(i_st, 8'h1A);
		wr_reg(i_en, 8'h0F);
		wr_reg(i_lo, 8'h20);
		wq.delete();
		repeat (81) set_in(4'hF, 1'b1);
		repeat (4) void'(wq.pop_front());
		rd_exp(i_st, 8'h1A);
		wr_reg(i_cur, 8'h1B);
		repeat (2) rd_exp(i_win, 8'h00);
		repeat (2) word(1'b0, i_win);
		rd_exp(i_cur, 8'h1D);
		for (n = 0; n < 3; n++) begin
			wr_reg(i_lo, 8'h00);
			rd_exp(i_cnt, 8'h00);
			wr_reg(i_hi, 8'h04);
			wr_reg(i_lo, (n == 2) ? 8'h30 : 8'h38);
			repeat (2) set_in(4'hF, 1'b0);
			frame_sync_pin <= (n != 1);
			act <= (n == 1);
			@(posedge clk);
			act <= 1'b0;
			repeat (6) @(posedge clk);
			repeat (3) set_in(4'hF, 1'b0);
			rd_exp(i_cnt, (n == 2) ? 8'h14 : 8'h0C);
			rd_exp(i_st, 8'h18);
			frame_sync_pin <= 1'b0;
		end
		repeat (4) @(posedge clk);
		close_out();
	end
endmodule : testbench
`default_nettype wire
